// >>> dfm_pkg.sv
// ==========================================================
// object indices, reset values, field positions, timing
package dfm_pkg;
  localparam logic [15:0] IDX_BL_SELECT = 16'h3704;
  localparam logic [15:0] IDX_BL_AMOUNT = 16'h3705;
  localparam logic [15:0] IDX_BL_TIME = 16'h3706;
  localparam logic [15:0] IDX_TRIG_SEL = 16'h3758;
  localparam logic [15:0] IDX_WARN_HOLD = 16'h3759;
  localparam logic [15:0] IDX_DSW_COUNT = 16'h3781;
  localparam logic [15:0] IDX_COMM_CTRL = 16'h3800;

  localparam logic [15:0] RST_BL_SELECT = 16'h0000;
  localparam logic [15:0] RST_BL_AMOUNT = 16'h0000;
  localparam logic [15:0] RST_BL_TIME = 16'h0000;
  localparam logic [15:0] RST_TRIG_SEL = 16'h0000;
  localparam logic [15:0] RST_WARN_HOLD = 16'h0000;
  localparam logic [15:0] RST_DSW_COUNT = 16'h0001;
  localparam logic [15:0] RST_COMM_CTRL = 16'h4000;

  localparam logic [15:0] MAX_BL_SELECT = 16'h0002;
  localparam logic [15:0] MAX_BL_TIME = 16'h1900;
  localparam logic [15:0] MAX_DSW_COUNT = 16'h000F;

  // backlash direction codes
  localparam logic [1:0] BL_DIR_OFF = 2'h0;
  localparam logic [1:0] BL_DIR_POS = 2'h1;
  localparam logic [1:0] BL_DIR_NEG = 2'h2;

  // field positions
  localparam int TRIG1_LO = 0;
  localparam int TRIG1_HI = 1;
  localparam int TRIG2_LO = 8;
  localparam int TRIG2_HI = 9;
  localparam int HOLD_COMM_BIT = 0;
  localparam int HOLD_GEN_BIT = 1;
  localparam int MASK_STATE_CHG = 1;
  localparam int MASK_ILLEGAL_CHG = 2;
  localparam int MASK_COMM_SYNC = 3;
  localparam int MASK_WARN_DATA = 4;
  localparam int MASK_WARN_CMD = 5;
  localparam int MASK_WARN_COMM = 6;
  localparam int MASK_SYNC = 12;
  localparam int MASK_SM_WDT = 13;
  localparam int MASK_DSW_ESC = 14;

  // warning lanes
  localparam int WARN_LANES = 5;
  localparam int LANE_DATA = 0;
  localparam int LANE_CMD = 1;
  localparam int LANE_COMM = 2;
  localparam int LANE_GEN = 3;
  localparam int LANE_LIFE = 4;

  // latch trigger sources
  typedef enum logic [1:0]
  {
    DFM_SRC_INPUT_FIRST = 2'h0,
    DFM_SRC_INPUT_SECOND = 2'h1,
    DFM_SRC_INPUT_THIRD = 2'h2,
    DFM_SRC_INDEX = 2'h3
  } dfm_src_t;

  // backlash arming, gray along idle, armed, done
  typedef enum logic [1:0]
  {
    DFM_BL_IDLE = 2'h0,
    DFM_BL_ARMED = 2'h1,
    DFM_BL_DONE = 2'h3
  } dfm_bl_state_t;

  // timing
  localparam longint CLK_HZ = 50000000;
  localparam longint WARN_HOLD_MIN_S = 1;
  localparam logic [31:0] WARN_HOLD_CYCLES = 32'(WARN_HOLD_MIN_S * CLK_HZ);
endpackage : dfm_pkg

// >>> dfm_warn_hold.sv
`timescale 1ns/1ns
// ==========================================================
// per lane warning holder: auto clear after a minimum time, or held until reset
module dfm_warn_hold
  import dfm_pkg::*;
#(
  parameter int LANES = WARN_LANES,
  parameter logic [31:0] HOLD_CYCLES = WARN_HOLD_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // lane control
  input wire logic [LANES-1:0] cause,
  input wire logic [LANES-1:0] hold_mode,
  input wire logic reset_cmd,
  // lane state
  output logic [LANES-1:0] active
);
  logic [31:0] timer [LANES];

  // ==========================================================
  // cause re-arms the timer, so a set always beats any clear
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active <= '0;
      for (int i = 0; i < LANES; i++)
      begin
        timer[i] <= 32'h0000_0000;
      end
    end
    else
    begin
      for (int i = 0; i < LANES; i++)
      begin
        if (cause[i])
        begin
          active[i] <= 1'b1;
          timer[i] <= HOLD_CYCLES - 32'h0000_0001; // see RULE7
        end
        else if (active[i])
        begin
          if (timer[i] != 32'h0000_0000)
          begin
            timer[i] <= timer[i] - 32'h0000_0001;
          end
          if (hold_mode[i])
          begin
            if (reset_cmd)
            begin
              active[i] <= 1'b0; // see RULE8
            end
          end
          else if (timer[i] == 32'h0000_0000)
          begin
            active[i] <= 1'b0; // see RULE7
          end
        end
      end
    end
  end
endmodule : dfm_warn_hold

// >>> dfm_object_bank.sv
`timescale 1ns/1ns
// Behaviour
// RULE1: backlash select 0 off, 1 first positive move, 2 first negative move.
// RULE2: backlash amount signed 16 bit, reset zero, used in position control only.
// RULE3: backlash time constant 0 to 6400 in 0.01 ms, reset zero.
// RULE4: latch 1 source from bits 0 and 1 of trigger word.
// RULE5: latch 2 source from bits 8 and 9, same encoding.
// RULE6: hold bit 0 rules communication warnings, bit 1 general warnings.
// RULE7: hold bit clear: warning auto clears, yet stays at least 1 s.
// RULE8: hold bit set: warning stays until cause gone and reset command.
// RULE9: life expectancy warning is always held.
// RULE10: consecutive data setting warnings beyond threshold raise command error.
// RULE11: threshold 1 means two warnings in a row raise the error.
// RULE12: control word resets with bit 14 set, blocking data warning escalation.
// RULE13: control bits 1,2,3,12,13 mask their communication errors.
// RULE14: bit 14 masks only data-warning command errors, others still report; the code also blocks the data setting warning lane itself.
// RULE15: master leaves the control word at reset value in normal use.
// RULE16: control bits 4,5,6 mask data, command and communication warnings.
// RULE17: other trigger word bits store and read back, no source effect.
module dfm_object_bank
  import dfm_pkg::*;
#(
  parameter logic [31:0] HOLD_CYCLES = WARN_HOLD_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // object access
  input wire logic obj_req,
  input wire logic obj_we,
  input wire logic [15:0] obj_index,
  input wire logic [15:0] obj_wdata,
  output logic obj_ack,
  output logic obj_err,
  output logic [15:0] obj_rdata,
  // drive status
  input wire logic servo_on,
  input wire logic pos_ctrl,
  input wire logic move_pos,
  input wire logic move_neg,
  // backlash outputs
  output logic [15:0] backlash_amount,
  output logic [15:0] backlash_time_const,
  output logic backlash_apply,
  // latch sources
  output dfm_src_t latch1_src,
  output dfm_src_t latch2_src,
  // warning causes and commands
  input wire logic dsw_detect,
  input wire logic dsw_clear,
  input wire logic cmd_warn_cause,
  input wire logic comm_warn_cause,
  input wire logic gen_warn_cause,
  input wire logic life_warn_cause,
  input wire logic warn_reset_cmd,
  // error causes and commands
  input wire logic other_cmd_err,
  input wire logic err_reset_cmd,
  input wire logic [4:0] comm_err_cause,
  // status
  output logic [WARN_LANES-1:0] warn_active,
  output logic cmd_error,
  output logic [4:0] comm_err
);
  logic [15:0] bl_select;
  logic [15:0] bl_amount;
  logic [15:0] bl_time;
  logic [15:0] trig_sel;
  logic [15:0] warn_hold;
  logic [15:0] dsw_thresh;
  logic [15:0] comm_ctrl;
  logic wr_ok;
  logic wr_bad;
  logic dsw_event;
  logic dsw_ok;
  logic [4:0] dsw_count;
  logic [4:0] next_dsw_count;
  logic dsw_escalate;
  logic [WARN_LANES-1:0] warn_cause;
  logic [WARN_LANES-1:0] warn_mode;
  logic [4:0] err_mask;
  dfm_bl_state_t bl_state;

  // ==========================================================
  // decoding
  function automatic logic idx_known(input logic [15:0] idx);
    idx_known = (idx == IDX_BL_SELECT) || (idx == IDX_BL_AMOUNT) ||
                (idx == IDX_BL_TIME) || (idx == IDX_TRIG_SEL) ||
                (idx == IDX_WARN_HOLD) || (idx == IDX_DSW_COUNT) ||
                (idx == IDX_COMM_CTRL);
  endfunction : idx_known

  // unsigned range limits; signed and full range words always pass
  function automatic logic in_range(input logic [15:0] idx, input logic [15:0] val);
    case (idx)
      IDX_BL_SELECT: in_range = (val <= MAX_BL_SELECT); // see RULE1
      IDX_BL_TIME: in_range = (val <= MAX_BL_TIME); // see RULE3
      IDX_DSW_COUNT: in_range = (val <= MAX_DSW_COUNT); // see RULE10
      default: in_range = idx_known(idx);
    endcase
  endfunction : in_range

  assign wr_ok = obj_req && obj_we && in_range(obj_index, obj_wdata);
  assign wr_bad = obj_req && obj_we && !in_range(obj_index, obj_wdata);

  // ==========================================================
  // object store; a rejected write leaves the old value in place
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bl_select <= RST_BL_SELECT;
      bl_amount <= RST_BL_AMOUNT; // see RULE2
      bl_time <= RST_BL_TIME; // see RULE3
      trig_sel <= RST_TRIG_SEL;
      warn_hold <= RST_WARN_HOLD;
      dsw_thresh <= RST_DSW_COUNT; // see RULE11
      comm_ctrl <= RST_COMM_CTRL; // see RULE12
    end
    else if (wr_ok)
    begin
      case (obj_index)
        IDX_BL_SELECT: bl_select <= obj_wdata;
        IDX_BL_AMOUNT: bl_amount <= obj_wdata; // see RULE2
        IDX_BL_TIME: bl_time <= obj_wdata;
        IDX_TRIG_SEL: trig_sel <= obj_wdata; // see RULE17
        IDX_WARN_HOLD: warn_hold <= obj_wdata;
        IDX_DSW_COUNT: dsw_thresh <= obj_wdata;
        IDX_COMM_CTRL: comm_ctrl <= obj_wdata;
        default: bl_select <= bl_select;
      endcase
    end
  end

  // ==========================================================
  // access answer, one cycle after the request
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      obj_ack <= 1'b0;
      obj_err <= 1'b0;
      obj_rdata <= 16'h0000;
    end
    else
    begin
      obj_ack <= obj_req;
      obj_err <= obj_req && (obj_we ? !in_range(obj_index, obj_wdata) : !idx_known(obj_index));
      if (obj_req && !obj_we)
      begin
        case (obj_index)
          IDX_BL_SELECT: obj_rdata <= bl_select;
          IDX_BL_AMOUNT: obj_rdata <= bl_amount;
          IDX_BL_TIME: obj_rdata <= bl_time;
          IDX_TRIG_SEL: obj_rdata <= trig_sel; // see RULE17
          IDX_WARN_HOLD: obj_rdata <= warn_hold;
          IDX_DSW_COUNT: obj_rdata <= dsw_thresh;
          IDX_COMM_CTRL: obj_rdata <= comm_ctrl;
          default: obj_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ==========================================================
  // latch source selection, only the two field pairs matter
  assign latch1_src = dfm_src_t'({trig_sel[TRIG1_HI], trig_sel[TRIG1_LO]}); // see RULE4
  assign latch2_src = dfm_src_t'({trig_sel[TRIG2_HI], trig_sel[TRIG2_LO]}); // see RULE5
  assign backlash_amount = bl_amount;
  assign backlash_time_const = bl_time;

  // ==========================================================
  // backlash arming: one shot per servo-on, position control only
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bl_state <= DFM_BL_IDLE;
      backlash_apply <= 1'b0;
    end
    else
    begin
      backlash_apply <= 1'b0;
      case (bl_state)
        DFM_BL_IDLE:
        begin
          if (servo_on && bl_select[1:0] != BL_DIR_OFF)
          begin
            bl_state <= DFM_BL_ARMED; // see RULE1
          end
        end
        DFM_BL_ARMED:
        begin
          if (!servo_on)
          begin
            bl_state <= DFM_BL_IDLE;
          end
          else if (pos_ctrl && ((bl_select[1:0] == BL_DIR_POS && move_pos) ||
                                (bl_select[1:0] == BL_DIR_NEG && move_neg)))
          begin
            backlash_apply <= 1'b1; // see RULE1
            bl_state <= DFM_BL_DONE;
          end
        end
        DFM_BL_DONE:
        begin
          if (!servo_on)
          begin
            bl_state <= DFM_BL_IDLE;
          end
        end
        default: bl_state <= DFM_BL_IDLE;
      endcase
    end
  end

  // ==========================================================
  // data setting warning run counter; a failed write counts as one
  assign dsw_event = (dsw_detect || wr_bad) && !comm_ctrl[MASK_DSW_ESC]; // see RULE12
  assign dsw_ok = dsw_clear || wr_ok;

  always_comb
  begin
    next_dsw_count = dsw_count;
    if (dsw_event && dsw_count != 5'h1F)
    begin
      next_dsw_count = dsw_count + 5'h01;
    end
    else if (dsw_ok)
    begin
      next_dsw_count = 5'h00;
    end
  end

  // threshold n escalates on the (n+1)th warning in a row
  assign dsw_escalate = dsw_event && (next_dsw_count >= dsw_thresh[4:0] + 5'h01); // see RULE10

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dsw_count <= 5'h00;
    end
    else
    begin
      dsw_count <= next_dsw_count;
    end
  end

  // ==========================================================
  // command error: sticky, the set beats a reset in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_error <= 1'b0;
    end
    else if (dsw_escalate || other_cmd_err)
    begin
      cmd_error <= 1'b1; // see RULE14
    end
    else if (err_reset_cmd)
    begin
      cmd_error <= 1'b0;
    end
  end

  // ==========================================================
  // communication error masks
  assign err_mask = {comm_ctrl[MASK_SM_WDT], comm_ctrl[MASK_SYNC], comm_ctrl[MASK_COMM_SYNC],
                     comm_ctrl[MASK_ILLEGAL_CHG], comm_ctrl[MASK_STATE_CHG]};

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      comm_err <= 5'h00;
    end
    else
    begin
      comm_err <= comm_err_cause & ~err_mask; // see RULE13
    end
  end

  // ==========================================================
  // warnings
  assign warn_cause[LANE_DATA] = dsw_event && !comm_ctrl[MASK_WARN_DATA]; // see RULE16
  assign warn_cause[LANE_CMD] = cmd_warn_cause && !comm_ctrl[MASK_WARN_CMD]; // see RULE16
  assign warn_cause[LANE_COMM] = comm_warn_cause && !comm_ctrl[MASK_WARN_COMM]; // see RULE16
  assign warn_cause[LANE_GEN] = gen_warn_cause;
  assign warn_cause[LANE_LIFE] = life_warn_cause;
  assign warn_mode[LANE_DATA] = warn_hold[HOLD_COMM_BIT]; // see RULE6
  assign warn_mode[LANE_CMD] = warn_hold[HOLD_COMM_BIT]; // see RULE6
  assign warn_mode[LANE_COMM] = warn_hold[HOLD_COMM_BIT]; // see RULE6
  assign warn_mode[LANE_GEN] = warn_hold[HOLD_GEN_BIT]; // see RULE6
  assign warn_mode[LANE_LIFE] = 1'b1; // see RULE9

  dfm_warn_hold #(
    .LANES(WARN_LANES),
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_warn_hold (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cause(warn_cause),
    .hold_mode(warn_mode),
    .reset_cmd(warn_reset_cmd),
    .active(warn_active)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  time_range_a: assert property ( // see RULE3
    obj_req && obj_we && obj_index == IDX_BL_TIME && obj_wdata > MAX_BL_TIME
    |=> obj_err && obj_ack && $stable(backlash_time_const))
    else $error("time constant accepted out of range");

  amount_store_a: assert property ( // see RULE2
    obj_req && obj_we && obj_index == IDX_BL_AMOUNT
    |=> backlash_amount == $past(obj_wdata) && !obj_err)
    else $error("backlash amount not stored");

  latch1_sel_a: assert property ( // see RULE4
    obj_req && obj_we && obj_index == IDX_TRIG_SEL
    |=> latch1_src == dfm_src_t'($past(obj_wdata[TRIG1_HI:TRIG1_LO])))
    else $error("latch 1 source wrong");

  latch2_sel_a: assert property ( // see RULE5
    obj_req && obj_we && obj_index == IDX_TRIG_SEL
    |=> latch2_src == dfm_src_t'($past(obj_wdata[TRIG2_HI:TRIG2_LO])))
    else $error("latch 2 source wrong");

  trig_readback_a: assert property ( // see RULE17
    obj_req && obj_we && obj_index == IDX_TRIG_SEL ##1 !obj_req ##1
    obj_req && !obj_we && obj_index == IDX_TRIG_SEL
    |=> obj_rdata == $past(obj_wdata, 3))
    else $error("trigger word readback differs");

  backlash_pos_a: assert property ( // see RULE1
    backlash_apply |-> $past(pos_ctrl) && $past(bl_select[1:0]) != BL_DIR_OFF &&
    $past(servo_on))
    else $error("backlash applied outside position control");

  escalate_a: assert property ( // see RULE10
    dsw_event && dsw_count >= dsw_thresh[4:0] |=> cmd_error)
    else $error("command error missing after warning run");

  esc_masked_a: assert property ( // see RULE12
    comm_ctrl[MASK_DSW_ESC] && !other_cmd_err && !cmd_error |=> !cmd_error)
    else $error("command error escalated while masked");

  other_cmd_a: assert property ( // see RULE14
    other_cmd_err |=> cmd_error)
    else $error("other command error lost");

  err_mask_a: assert property ( // see RULE13
    err_mask[0] && comm_err_cause[0] |=> !comm_err[0])
    else $error("masked state change error reported");

  life_hold_a: assert property ( // see RULE9
    warn_active[LANE_LIFE] && !warn_reset_cmd |=> warn_active[LANE_LIFE])
    else $error("life warning cleared without reset");

  gen_hold_a: assert property ( // see RULE8
    warn_hold[HOLD_GEN_BIT] && warn_active[LANE_GEN] && !warn_reset_cmd
    |=> warn_active[LANE_GEN])
    else $error("held general warning cleared");

  auto_min_a: assert property ( // see RULE7
    !warn_hold[HOLD_GEN_BIT] && $rose(warn_active[LANE_GEN]) |-> warn_active[LANE_GEN][*8])
    else $error("auto warning dropped too early");

  esc_hit_c: cover property (dsw_escalate);
  backlash_c: cover property (backlash_apply);
  life_clear_c: cover property (warn_active[LANE_LIFE] ##1 !warn_active[LANE_LIFE]);
  trig_write_c: cover property (obj_req && obj_we && obj_index == IDX_TRIG_SEL);
endmodule : dfm_object_bank

// >>> dfm_master_model.sv
`timescale 1ns/1ns
// ==========================================================
// fieldbus master model: one object access at a time
module dfm_master_model
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // object access
  output logic obj_req,
  output logic obj_we,
  output logic [15:0] obj_index,
  output logic [15:0] obj_wdata,
  input wire logic obj_ack,
  input wire logic obj_err,
  input wire logic [15:0] obj_rdata
);
  initial
  begin
    obj_req = 1'h0;
    obj_we = 1'h0;
    obj_index = 16'h0000;
    obj_wdata = 16'h0000;
  end

  // ==========================================================
  // access: request stands one cycle, since each high cycle is a new request
  task automatic access(input logic we, input logic [15:0] idx, input logic [15:0] wd,
                        output logic err, output logic [15:0] rd);
    int n;
    n = 0;
    while (rst_n !== 1'h1)
      @(posedge clk_sys);
    @(posedge clk_sys);
    obj_req <= 1'h1;
    obj_we <= we;
    obj_index <= idx;
    obj_wdata <= wd;
    @(posedge clk_sys);
    obj_req <= 1'h0;
    // released lines show the inverse so stale values never pass for live ones
    obj_index <= ~idx;
    obj_wdata <= ~wd;
    @(negedge clk_sys);
    while (obj_ack !== 1'h1 && n < 4)
    begin
      @(negedge clk_sys);
      n++;
    end
    err = (n < 4) ? obj_err : 1'hX;
    rd = (n < 4) ? obj_rdata : 16'hXXXX;
  endtask : access
endmodule : dfm_master_model

// >>> dfm_object_bank_tb.sv
`timescale 1ns/1ns
// ==========================================================
// object bank bench: table of register cases, then hand-written scenarios
module dfm_object_bank_tb
  import dfm_pkg::*;
;
  typedef struct {
    logic [15:0] idx; logic [15:0] wd; logic werr; logic rerr;
    logic [15:0] rd; logic [1:0] l1; logic [1:0] l2;
  } dfm_tb_row_t;
  localparam int LIMIT = 20000;
  logic clk_sys = 1'h0, rst_n = 1'h0, servo_on = 1'h0, pos_ctrl = 1'h1;
  logic [1:0] mv = 2'h0;
  logic [4:0] pls = 5'h00, ce = 5'h00;
  logic [3:0] cs = 4'h0;
  logic obj_req, obj_we, obj_ack, obj_err, backlash_apply, cmd_error;
  logic [15:0] obj_index, obj_wdata, obj_rdata, backlash_amount, backlash_time_const;
  logic [WARN_LANES-1:0] warn_active;
  logic [4:0] comm_err;
  dfm_src_t latch1_src, latch2_src;
  int n_mismatch = 0, tests_run = 0, cyc = 0;
  int mb [5] = '{1, 2, 3, 12, 13};
  logic [15:0] ridx [7] = '{IDX_BL_SELECT, IDX_BL_AMOUNT, IDX_BL_TIME, IDX_TRIG_SEL,
                            IDX_WARN_HOLD, IDX_DSW_COUNT, IDX_COMM_CTRL};
  logic [15:0] rrst [7] = '{RST_BL_SELECT, RST_BL_AMOUNT, RST_BL_TIME, RST_TRIG_SEL,
                            RST_WARN_HOLD, RST_DSW_COUNT, RST_COMM_CTRL};
  dfm_tb_row_t rows [17] = '{
    '{IDX_BL_AMOUNT, 16'h8000, 1'h0, 1'h0, 16'h8000, 2'h0, 2'h0},
    '{IDX_BL_AMOUNT, 16'h7FFF, 1'h0, 1'h0, 16'h7FFF, 2'h0, 2'h0},
    '{IDX_BL_TIME, 16'h1900, 1'h0, 1'h0, 16'h1900, 2'h0, 2'h0},
    '{IDX_BL_TIME, 16'h1901, 1'h1, 1'h0, 16'h1900, 2'h0, 2'h0},
    '{IDX_BL_TIME, 16'hFFFF, 1'h1, 1'h0, 16'h1900, 2'h0, 2'h0},
    '{IDX_TRIG_SEL, 16'h0101, 1'h0, 1'h0, 16'h0101, 2'h1, 2'h1},
    '{IDX_TRIG_SEL, 16'h0202, 1'h0, 1'h0, 16'h0202, 2'h2, 2'h2},
    '{IDX_TRIG_SEL, 16'h0201, 1'h0, 1'h0, 16'h0201, 2'h1, 2'h2},
    '{IDX_TRIG_SEL, 16'hA5C3, 1'h0, 1'h0, 16'hA5C3, 2'h3, 2'h1},
    '{IDX_TRIG_SEL, 16'hFCFC, 1'h0, 1'h0, 16'hFCFC, 2'h0, 2'h0},
    '{IDX_DSW_COUNT, 16'h000F, 1'h0, 1'h0, 16'h000F, 2'h0, 2'h0},
    '{IDX_DSW_COUNT, 16'h0010, 1'h1, 1'h0, 16'h000F, 2'h0, 2'h0},
    '{IDX_BL_SELECT, 16'h0002, 1'h0, 1'h0, 16'h0002, 2'h0, 2'h0},
    '{IDX_BL_SELECT, 16'h0003, 1'h1, 1'h0, 16'h0002, 2'h0, 2'h0},
    '{IDX_WARN_HOLD, 16'hFFFF, 1'h0, 1'h0, 16'hFFFF, 2'h0, 2'h0},
    '{IDX_WARN_HOLD, 16'h0000, 1'h0, 1'h0, 16'h0000, 2'h0, 2'h0},
    '{16'h3707, 16'h1234, 1'h1, 1'h1, 16'h0000, 2'h0, 2'h0}};

  always #10 clk_sys = ~clk_sys;

  dfm_master_model mst (.clk_sys(clk_sys), .rst_n(rst_n), .obj_req(obj_req), .obj_we(obj_we),
    .obj_index(obj_index), .obj_wdata(obj_wdata), .obj_ack(obj_ack), .obj_err(obj_err),
    .obj_rdata(obj_rdata));

  dfm_object_bank #(.HOLD_CYCLES(32'h0000_0010)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .obj_req(obj_req), .obj_we(obj_we), .obj_index(obj_index), .obj_wdata(obj_wdata),
    .obj_ack(obj_ack), .obj_err(obj_err), .obj_rdata(obj_rdata), .servo_on(servo_on),
    .pos_ctrl(pos_ctrl), .move_pos(mv[0]), .move_neg(mv[1]),
    .backlash_amount(backlash_amount), .backlash_time_const(backlash_time_const),
    .backlash_apply(backlash_apply), .latch1_src(latch1_src), .latch2_src(latch2_src),
    .dsw_detect(pls[0]), .dsw_clear(pls[1]), .cmd_warn_cause(cs[0]), .comm_warn_cause(cs[1]),
    .gen_warn_cause(cs[2]), .life_warn_cause(cs[3]), .warn_reset_cmd(pls[2]),
    .other_cmd_err(pls[3]), .err_reset_cmd(pls[4]), .comm_err_cause(ce),
    .warn_active(warn_active), .cmd_error(cmd_error), .comm_err(comm_err));

  // ==========================================================
  // shared tasks
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task automatic wr(input logic [15:0] idx, input logic [15:0] wd, input logic ee);
    logic err;
    logic [15:0] rd;
    mst.access(1'h1, idx, wd, err, rd);
    chk("obj_err write", 16'(ee), 16'(err));
  endtask : wr

  task automatic rdchk(input logic [15:0] idx, input logic [15:0] e, input logic ee);
    logic err;
    logic [15:0] rd;
    mst.access(1'h0, idx, 16'h0000, err, rd);
    chk("obj_err read", 16'(ee), 16'(err));
    chk("obj_rdata", e, rd);
  endtask : rdchk

  // one cycle pulse, then two edges for the registered answer to settle
  task automatic pulse(input int b);
    @(posedge clk_sys) pls[b] <= 1'h1;
    @(posedge clk_sys) pls[b] <= 1'h0;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : pulse

  task automatic move(input int d, input logic e);
    @(posedge clk_sys) mv[d] <= 1'h1;
    @(posedge clk_sys) mv[d] <= 1'h0;
    @(negedge clk_sys);
    chk("backlash_apply", 16'(e), 16'(backlash_apply));
  endtask : move

  task automatic chk_reset(input string name);
    for (int i = 0; i < 7; i++)
      rdchk(ridx[i], rrst[i], 1'h0);
    chk("warn_active", 16'h0000, 16'(warn_active));
    chk("cmd_error", 16'h0000, 16'(cmd_error));
    $display("test %s done", name);
  endtask : chk_reset

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      end_of_test;
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'h1;
    chk_reset("reset");
    foreach (rows[i])
    begin
      wr(rows[i].idx, rows[i].wd, rows[i].werr);
      rdchk(rows[i].idx, rows[i].rd, rows[i].rerr);
      chk("latch1_src", 16'(rows[i].l1), 16'(latch1_src));
      chk("latch2_src", 16'(rows[i].l2), 16'(latch2_src));
    end
    chk("backlash_amount", 16'h7FFF, backlash_amount);
    chk("backlash_time_const", 16'h1900, backlash_time_const);
    $display("test rows done");
    for (int d = 0; d < 3; d++)
    begin
      wr(IDX_BL_SELECT, 16'(d), 1'h0);
      @(posedge clk_sys) servo_on <= 1'h1;
      repeat (2) @(posedge clk_sys);
      move((d == 1) ? 1 : 0, 1'h0);
      move((d == 2) ? 1 : 0, d != 0);
      move((d == 2) ? 1 : 0, 1'h0);
      @(posedge clk_sys) servo_on <= 1'h0;
    end
    wr(IDX_BL_SELECT, 16'h0001, 1'h0);
    @(posedge clk_sys) servo_on <= 1'h1;
    pos_ctrl <= 1'h0;
    repeat (2) @(posedge clk_sys);
    move(0, 1'h0);
    @(posedge clk_sys) pos_ctrl <= 1'h1;
    move(0, 1'h1);
    @(posedge clk_sys) servo_on <= 1'h0;
    $display("test backlash done");
    wr(IDX_COMM_CTRL, 16'h0000, 1'h0);
    foreach (mb[k])
    begin
      if (k == 2 || k > 3)
        continue;
      wr(IDX_DSW_COUNT, 16'(k), 1'h0);
      pulse(4);
      repeat (k) pulse(0);
      chk("cmd_error", 16'h0000, 16'(cmd_error));
      pulse(0);
      chk("cmd_error", 16'h0001, 16'(cmd_error));
    end
    chk("warn_active", 16'h0001, 16'(warn_active[0]));
    wr(IDX_DSW_COUNT, 16'h0001, 1'h0);
    pulse(4);
    pulse(0);
    pulse(1);
    pulse(0);
    chk("cmd_error", 16'h0000, 16'(cmd_error));
    wr(IDX_DSW_COUNT, 16'h0010, 1'h1);
    repeat (2) @(negedge clk_sys);
    chk("cmd_error", 16'h0001, 16'(cmd_error));
    wr(IDX_COMM_CTRL, 16'h4000, 1'h0);
    pulse(4);
    repeat (3) pulse(0);
    chk("cmd_error", 16'h0000, 16'(cmd_error));
    pulse(3);
    chk("cmd_error", 16'h0001, 16'(cmd_error));
    pulse(4);
    $display("test escalation done");
    for (int h = 0; h < 4; h++)
    begin
      wr(IDX_WARN_HOLD, 16'(h), 1'h0);
      @(posedge clk_sys) cs <= 4'hF;
      repeat (2) @(posedge clk_sys);
      cs <= 4'h0;
      repeat (6) @(negedge clk_sys);
      chk("warn_active", 16'h000F, 16'(warn_active[4:1]));
      repeat (20) @(negedge clk_sys);
      chk("warn_active", 16'({1'h1, h[1], h[0], h[0]}), 16'(warn_active[4:1]));
      pulse(2);
      chk("warn_active", 16'h0000, 16'(warn_active));
    end
    wr(IDX_COMM_CTRL, 16'h0070, 1'h0);
    @(posedge clk_sys) cs <= 4'hF;
    pulse(0);
    chk("warn_active", 16'h0018, 16'(warn_active));
    @(posedge clk_sys) cs <= 4'h0;
    wr(IDX_COMM_CTRL, 16'h4000, 1'h0);
    pulse(2);
    pulse(4);
    $display("test warnings done");
    foreach (mb[k])
    begin
      wr(IDX_COMM_CTRL, 16'h4000 | 16'(1 << mb[k]), 1'h0);
      @(posedge clk_sys) ce <= 5'h1F;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk("comm_err", 16'(5'h1F & ~(5'h01 << k)), 16'(comm_err));
      @(posedge clk_sys) ce <= 5'h00;
    end
    wr(IDX_COMM_CTRL, 16'h4000, 1'h0);
    $display("test comm_err done");
    wr(IDX_BL_AMOUNT, 16'h1234, 1'h0);
    @(posedge clk_sys) rst_n <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'h1;
    chk_reset("mid_reset");
    end_of_test;
  end
endmodule : dfm_object_bank_tb
